// >>> rtl/ssa_alu.v
// scaled and saturating subtract datapath with its own flag state
// assumes: pipeline presents decoded operands for one cycle with opValid,
// all inputs synchronous to clk; software reaches the flags over a plain port
//
// Functional notes
// (RL1) scale-by-two subtract: result is first minus second shifted left one
// (RL2) scale-by-four subtract: result is first minus second shifted left two
// (RL3) scale-by-eight subtract: result is first minus second shifted left three
// (RL4) scaled subtract overflow covers only the final subtraction, not shift loss
// (RL5) plain and scaled subtracts set carry when a borrow occurs
// (RL6) flags change only when the flag-set bit is one
// (RL7) zero flag when result is zero, negative flag copies result bit 31
// (RL8) signed saturating subtract clamps to largest or most negative 32-bit value
// (RL9) saturating subtracts set overflow if clamped, clear it otherwise
// (RL10) 32-bit saturating subtract sets sticky saturation, never clears it
// (RL11) 32-bit saturating subtract clamping sets both lane saturation flags
// (RL12) 32-bit saturating subtract sets carry when the subtraction borrows
// (RL13) dual-lane subtract clamps each 16-bit lane difference, then concatenates
// (RL14) upper and lower lane flags follow clamping of their own lane
// (RL15) no-write destination code discards result, keeps the flag updates
// (RL16) word swap exchanges the low and high 16-bit halves of the source
// (RL17) false condition writes no destination and changes no flag
// (RL18) bits shifted above bit 31 are dropped before the 32-bit subtraction
`timescale 1ns/10ps
`include "ssa_alu_map.vh"

module ssa_alu #(
  parameter DATA_W = 32,
  parameter LANE_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire opValid,
  input wire [`SSA_OP_W-1:0] opSel,
  input wire [DATA_W-1:0] srcA,
  input wire [DATA_W-1:0] srcB,
  input wire condTrue,
  input wire setFlags,
  input wire [`SSA_DEST_W-1:0] destField,
  output reg [DATA_W-1:0] result_r,
  output reg [`SSA_DEST_W-1:0] resultDest_r,
  output reg resultWe_r,
  output reg opDone_r,
  output wire flagZero,
  output wire flagNeg,
  output wire flagCarry,
  output wire flagOvf,
  output wire flagSticky,
  output wire upperLaneSatFlag,
  output wire lowerLaneSatFlag,
  input wire [`SSA_ADDR_W-1:0] regAddr,
  input wire [DATA_W-1:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [DATA_W-1:0] regRdata_r
);

  // one lane of signed saturating subtract: {clamped, diff}
  function [LANE_W:0] satSub16;
    input [LANE_W-1:0] a;
    input [LANE_W-1:0] b;
    reg [LANE_W:0] wide;
    begin
      wide = {a[LANE_W-1], a} - {b[LANE_W-1], b};
      if (wide[LANE_W] != wide[LANE_W-1]) begin // [RL13]
        satSub16 = {1'b1, wide[LANE_W] ? `SSA_MIN16 : `SSA_MAX16};
      end else begin
        satSub16 = {1'b0, wide[LANE_W-1:0]};
      end
    end
  endfunction

  // result zero and sign, shared by every flag-setting operation
  function [1:0] zeroNeg;
    input [DATA_W-1:0] r;
    begin
      zeroNeg = {r[DATA_W-1], (r == {DATA_W{1'b0}})}; // [RL7]
    end
  endfunction

  reg [`SSA_FLAGS_W-1:0] flags_r;
  reg [`SSA_FLAGS_W-1:0] flags_nxt;
  reg [DATA_W-1:0] result_nxt;

  // scaled second operand and plain 32-bit subtraction
  reg [1:0] shiftAmt;
  reg [DATA_W-1:0] scaledB;
  reg [DATA_W:0] diffU;
  wire [DATA_W-1:0] diffLow;
  wire borrow;
  wire ovfSub;

  always @* begin
    case (opSel)
      `SSA_OP_SUB_X2: shiftAmt = `SSA_SHIFT_X2; // [RL1]
      `SSA_OP_SUB_X4: shiftAmt = `SSA_SHIFT_X4; // [RL2]
      `SSA_OP_SUB_X8: shiftAmt = `SSA_SHIFT_X8; // [RL3]
      default: shiftAmt = 2'h0;
    endcase
  end

  always @* begin
    // upper bits fall off the 32-bit word before subtracting [RL18]
    scaledB = srcB << shiftAmt;
    diffU = {1'b0, srcA} - {1'b0, scaledB};
  end

  assign diffLow = diffU[DATA_W-1:0];
  // carry out of the unsigned subtract means a borrow happened
  assign borrow = diffU[DATA_W]; // [RL5]
  // overflow judged from the shifted operand actually subtracted [RL4]
  assign ovfSub = (srcA[DATA_W-1] != scaledB[DATA_W-1]) &&
                  (diffLow[DATA_W-1] != srcA[DATA_W-1]);

  // 32-bit saturating subtract
  reg [DATA_W:0] diffS;
  reg [DATA_W-1:0] satRes;
  reg satHit;

  always @* begin
    diffS = {srcA[DATA_W-1], srcA} - {srcB[DATA_W-1], srcB};
    satHit = (diffS[DATA_W] != diffS[DATA_W-1]);
    if (satHit) begin
      satRes = diffS[DATA_W] ? `SSA_MIN32 : `SSA_MAX32; // [RL8]
    end else begin
      satRes = diffS[DATA_W-1:0];
    end
  end

  // dual-lane saturating subtract
  wire [LANE_W:0] laneHi;
  wire [LANE_W:0] laneLo;
  wire [DATA_W-1:0] dualRes;

  assign laneHi = satSub16(srcA[DATA_W-1:LANE_W], srcB[DATA_W-1:LANE_W]);
  assign laneLo = satSub16(srcA[LANE_W-1:0], srcB[LANE_W-1:0]);
  assign dualRes = {laneHi[LANE_W-1:0], laneLo[LANE_W-1:0]}; // [RL13]

  // word swap
  wire [DATA_W-1:0] swapRes;
  assign swapRes = {srcB[LANE_W-1:0], srcB[DATA_W-1:LANE_W]}; // [RL16]

  // an instruction actually executes only with a true condition
  wire execOp;
  wire writeDest;
  assign execOp = opValid && condTrue; // [RL17]
  assign writeDest = execOp && (destField != `SSA_DEST_NOWRITE); // [RL15]

  always @* begin
    case (opSel)
      `SSA_OP_SUB,
      `SSA_OP_SUB_X2,
      `SSA_OP_SUB_X4,
      `SSA_OP_SUB_X8: result_nxt = diffLow; // [RL1] [RL2] [RL3]
      `SSA_OP_SUBSAT: result_nxt = satRes;
      `SSA_OP_SUBDUAL: result_nxt = dualRes;
      `SSA_OP_SWAP: result_nxt = swapRes;
      default: result_nxt = {DATA_W{1'b0}};
    endcase
  end

  // flag next state: software write first, instruction update on top;
  // sticky saturation keeps a same-cycle hardware set over a software clear
  reg [`SSA_FLAGS_W-1:0] flagsBase;
  reg [1:0] zn;
  reg instFlags;

  always @* begin
    flagsBase = flags_r;
    if (regWr && (regAddr == `SSA_REG_FLAGS)) begin
      flagsBase = regWdata[`SSA_FLAGS_W-1:0];
    end
    flags_nxt = flagsBase;
    zn = zeroNeg(result_nxt);
    instFlags = execOp && setFlags; // [RL6] [RL17]
    if (instFlags) begin
      case (opSel)
        `SSA_OP_SUB,
        `SSA_OP_SUB_X2,
        `SSA_OP_SUB_X4,
        `SSA_OP_SUB_X8: begin
          flags_nxt[`SSA_FLAG_Z] = zn[0]; // [RL7]
          flags_nxt[`SSA_FLAG_N] = zn[1];
          flags_nxt[`SSA_FLAG_C] = borrow; // [RL5]
          flags_nxt[`SSA_FLAG_V] = ovfSub; // [RL4]
        end
        `SSA_OP_SUBSAT: begin
          flags_nxt[`SSA_FLAG_Z] = zn[0]; // [RL7]
          flags_nxt[`SSA_FLAG_N] = zn[1];
          flags_nxt[`SSA_FLAG_C] = borrow; // [RL12]
          flags_nxt[`SSA_FLAG_V] = satHit; // [RL9]
          flags_nxt[`SSA_FLAG_S] = flagsBase[`SSA_FLAG_S] | satHit; // [RL10]
          flags_nxt[`SSA_FLAG_UPPER] = satHit; // [RL11]
          flags_nxt[`SSA_FLAG_LOWER] = satHit; // [RL11]
        end
        `SSA_OP_SUBDUAL: begin
          // carry is left alone by the dual-lane form
          flags_nxt[`SSA_FLAG_Z] = zn[0]; // [RL7]
          flags_nxt[`SSA_FLAG_N] = zn[1];
          flags_nxt[`SSA_FLAG_V] = laneHi[LANE_W] | laneLo[LANE_W]; // [RL9]
          flags_nxt[`SSA_FLAG_S] = flagsBase[`SSA_FLAG_S] |
                                   laneHi[LANE_W] | laneLo[LANE_W];
          flags_nxt[`SSA_FLAG_UPPER] = laneHi[LANE_W]; // [RL14]
          flags_nxt[`SSA_FLAG_LOWER] = laneLo[LANE_W]; // [RL14]
        end
        `SSA_OP_SWAP: begin
          flags_nxt[`SSA_FLAG_Z] = zn[0]; // [RL7]
          flags_nxt[`SSA_FLAG_N] = zn[1];
        end
        default: begin
          flags_nxt = flagsBase;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      flags_r <= `SSA_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt; // [RL6]
    end
  end

  // result stage: holds the last written value between instructions
  always @(posedge clk) begin
    if (!rst_n) begin
      result_r <= {DATA_W{1'b0}};
      resultDest_r <= {`SSA_DEST_W{1'b0}};
      resultWe_r <= 1'b0;
      opDone_r <= 1'b0;
    end else begin
      resultWe_r <= writeDest; // [RL15] [RL17]
      opDone_r <= execOp;
      if (writeDest) begin
        result_r <= result_nxt;
        resultDest_r <= destField;
      end
    end
  end

  assign flagZero = flags_r[`SSA_FLAG_Z];
  assign flagNeg = flags_r[`SSA_FLAG_N];
  assign flagCarry = flags_r[`SSA_FLAG_C];
  assign flagOvf = flags_r[`SSA_FLAG_V];
  assign flagSticky = flags_r[`SSA_FLAG_S];
  assign upperLaneSatFlag = flags_r[`SSA_FLAG_UPPER];
  assign lowerLaneSatFlag = flags_r[`SSA_FLAG_LOWER];

  // register read port, data one cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (!rst_n) begin
      regRdata_r <= {DATA_W{1'b0}};
    end else if (regRd) begin
      case (regAddr)
        `SSA_REG_FLAGS: regRdata_r <= {{(DATA_W-`SSA_FLAGS_W){1'b0}}, flags_r};
        `SSA_REG_RESULT: regRdata_r <= result_r;
        default: regRdata_r <= {DATA_W{1'b0}};
      endcase
    end else begin
      regRdata_r <= {DATA_W{1'b0}};
    end
  end

endmodule // ssa_alu

// >>> rtl/ssa_alu_map.vh
// constants for the scaled and saturating subtract datapath
// assumes: included by rtl/ssa_alu.v only, plain Verilog-2005
`ifndef SSA_ALU_MAP_VH
`define SSA_ALU_MAP_VH

// operation select codes
`define SSA_OP_W 3
`define SSA_OP_SUB 3'h0
`define SSA_OP_SUB_X2 3'h1
`define SSA_OP_SUB_X4 3'h2
`define SSA_OP_SUB_X8 3'h3
`define SSA_OP_SUBSAT 3'h4
`define SSA_OP_SUBDUAL 3'h5
`define SSA_OP_SWAP 3'h6

// scale amounts of the scaled subtracts
`define SSA_SHIFT_X2 2'h1
`define SSA_SHIFT_X4 2'h2
`define SSA_SHIFT_X8 2'h3

// destination field code that means no register write
`define SSA_DEST_W 6
`define SSA_DEST_NOWRITE 6'h3e

// flag word layout
`define SSA_FLAGS_W 7
`define SSA_FLAG_Z 0
`define SSA_FLAG_N 1
`define SSA_FLAG_C 2
`define SSA_FLAG_V 3
`define SSA_FLAG_S 4
`define SSA_FLAG_UPPER 5
`define SSA_FLAG_LOWER 6
`define SSA_FLAGS_RST 7'h00

// register port
`define SSA_ADDR_W 8
`define SSA_REG_FLAGS 8'h00
`define SSA_REG_RESULT 8'h04

// saturation limits
`define SSA_MAX32 32'h7fffffff
`define SSA_MIN32 32'h80000000
`define SSA_MAX16 16'h7fff
`define SSA_MIN16 16'h8000

`endif

// >>> dv/ssa_wb_model.sv
// write-back side of the pipeline: a register file catching results
// assumes: result and destination stand steady in the cycle of the pulse
`timescale 1ns/10ps
module ssa_wb_model (
  input wire clk,
  input wire we,
  input wire [5:0] dest,
  input wire [31:0] data
);
  logic [31:0] mem [64];
  // only the write pulse may land, so a no-write op leaves no trace
  always @(posedge clk) begin
    if (we) begin
      mem[dest] <= data;
    end
  end
endmodule // ssa_wb_model

// >>> dv/ssa_alu_asserts.sv
// checker for the subtract datapath ports
// assumes: bound to every ssa_alu, one clock domain
`timescale 1ns/10ps
module ssa_alu_asserts (
  input wire clk,
  input wire rst_n,
  input wire opValid,
  input wire [2:0] opSel,
  input wire [31:0] srcA,
  input wire [31:0] srcB,
  input wire condTrue,
  input wire setFlags,
  input wire [5:0] destField,
  input wire [31:0] result_r,
  input wire resultWe_r,
  input wire opDone_r,
  input wire flagZero,
  input wire flagNeg,
  input wire flagCarry,
  input wire flagOvf,
  input wire flagSticky,
  input wire upperLaneSatFlag,
  input wire lowerLaneSatFlag,
  input wire regWr
);
  wire [6:0] fl = {lowerLaneSatFlag, upperLaneSatFlag, flagSticky, flagOvf, flagCarry,
    flagNeg, flagZero};
  wire go = opValid && condTrue;
  wire wr = go && destField != 6'h3e && opSel != 3'h7;
  wire sat = opSel == 3'h4 || opSel == 3'h5;
  wire [31:0] diffX2 = srcA - (srcB << 1);
  wire [31:0] swp = {srcB[15:0], srcB[31:16]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  op_done_a: assert property (go |=> opDone_r) else $error("op not done");
  cond_false_a: assert property (!go |=> !opDone_r && !resultWe_r)
    else $error("idle op acted");
  flag_hold_a: assert property ((!go || !setFlags) && !regWr |=> $stable(fl))
    else $error("flags moved");
  no_write_a: assert property (go && destField == 6'h3e |=>
    !resultWe_r && $stable(result_r)) else $error("no-write op wrote");
  scale_two_a: assert property (wr && opSel == 3'h1 |=>
    resultWe_r && result_r == $past(diffX2)) else $error("scaled result wrong");
  word_swap_a: assert property (wr && opSel == 3'h6 |=> result_r == $past(swp))
    else $error("swap result wrong");
  zero_neg_a: assert property (wr && setFlags |=>
    flagZero == (result_r == 32'h0) && flagNeg == result_r[31])
    else $error("zero or negative wrong");
  sat_ovf_a: assert property (go && setFlags && sat |=>
    flagOvf == (upperLaneSatFlag || lowerLaneSatFlag) && (!flagOvf || flagSticky))
    else $error("clamp flags");
  sticky_keep_a: assert property (flagSticky && !regWr |=> flagSticky)
    else $error("sticky lost");
  cover property (go && opSel == 3'h4);
  cover property (go && opSel == 3'h5);
  cover property (go && destField == 6'h3e);
endmodule // ssa_alu_asserts

bind ssa_alu ssa_alu_asserts ssa_alu_asserts_inst (.*);

// >>> dv/test_scaled_and_saturating_subtract_alu.sv
// self-checking bench for the subtract datapath
// assumes: ssa_alu, its checker and the write-back model compiled first
`timescale 1ns/10ps
module test_scaled_and_saturating_subtract_alu;
  typedef struct packed {
    logic [2:0] op;
    logic [31:0] a, b, r;
    logic [6:0] f;
  } ssa_row_t;
  logic clk = '0, rst_n = '0, opValid = '0, condTrue = '0, setFlags = '0;
  logic regWr = '0, regRd = '0, resultWe_r, opDone_r;
  logic [2:0] opSel = '0;
  logic [31:0] srcA = '0, srcB = '0, regWdata = '0, result_r, regRdata_r, rd;
  logic [5:0] destField = '0, resultDest_r;
  logic [7:0] regAddr = '0;
  logic [6:0] fl;
  int miscompares = 0, n_compared = 0, cyc = 0;
  ssa_row_t rows [10];

  ssa_alu ssa_alu_inst (.*, .flagZero(fl[0]), .flagNeg(fl[1]), .flagCarry(fl[2]),
    .flagOvf(fl[3]), .flagSticky(fl[4]), .upperLaneSatFlag(fl[5]), .lowerLaneSatFlag(fl[6]));
  ssa_wb_model ssa_wb_model_inst (.clk(clk), .we(resultWe_r), .dest(resultDest_r),
    .data(result_r));

  initial forever #2.5 clk = ~clk;

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      miscompares++;
      complete_run;
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic op(logic [2:0] o, logic [31:0] a, b, logic sf, ct, logic [5:0] d);
    @(posedge clk);
    opValid <= 1'b1;
    opSel <= o;
    srcA <= a;
    srcB <= b;
    setFlags <= sf;
    condTrue <= ct;
    destField <= d;
    @(posedge clk);
    opValid <= 1'b0;
    #1;
  endtask

  task automatic reg_io(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 rd = regRdata_r;
  endtask

  initial begin
    rows = '{'{3'h1, 32'ha, 32'h3, 32'h4, 7'h00},
      '{3'h2, 32'h0, 32'h1, 32'hfffffffc, 7'h06},
      '{3'h3, 32'h8, 32'h20000001, 32'h0, 7'h01},
      '{3'h0, 32'h80000000, 32'h1, 32'h7fffffff, 7'h08},
      '{3'h4, 32'h80000000, 32'h1, 32'h80000000, 7'h7a},
      '{3'h4, 32'h1, 32'h2, 32'hffffffff, 7'h16},
      '{3'h5, 32'h80000005, 32'h10003, 32'h80000002, 7'h3e},
      '{3'h5, 32'h7fff, 32'hffff, 32'h7fff, 7'h5c},
      '{3'h6, 32'h0, 32'h12345678, 32'h56781234, 7'h5c},
      '{3'h4, 32'h7fffffff, 32'hffffffff, 32'h7fffffff, 7'h7c}};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("reset flags", '0, {25'h0, fl});
    foreach (rows[i]) begin
      op(rows[i].op, rows[i].a, rows[i].b, 1'b1, 1'b1, 6'(i + 1));
      chk("flags", {25'h0, rows[i].f}, {25'h0, fl});
      @(posedge clk);
      #1 chk("result", rows[i].r, ssa_wb_model_inst.mem[i + 1]);
    end
    $display("table done");
    op(3'h0, 32'h3, 32'h1, 1'b0, 1'b1, 6'h20);
    chk("flags kept", 32'h7c, {25'h0, fl});
    op(3'h0, 32'h1, 32'h5, 1'b1, 1'b0, 6'h21);
    chk("done", '0, {31'h0, opDone_r});
    chk("cond flags", 32'h7c, {25'h0, fl});
    op(3'h0, 32'h5, 32'h5, 1'b1, 1'b1, 6'h3e);
    chk("write", '0, {31'h0, resultWe_r});
    chk("held result", 32'h2, result_r);
    chk("nowrite flags", 32'h71, {25'h0, fl});
    $display("condition and no-write done");
    reg_io(1'b0, 8'h00, '0);
    chk("flag reg", 32'h71, rd);
    reg_io(1'b1, 8'h00, 32'h3);
    chk("flag write", 32'h3, {25'h0, fl});
    // the result register is read-only, a write must not reach it
    reg_io(1'b1, 8'h04, 32'h5);
    reg_io(1'b0, 8'h04, '0);
    chk("last result", 32'h2, rd);
    @(posedge clk);
    #1 chk("read idle", '0, regRdata_r);
    reg_io(1'b0, 8'h08, '0);
    chk("unmapped", '0, rd);
    $display("register port done");
    // spare op code executes, writes zero and leaves the flags alone
    op(3'h7, 32'h9, 32'h1, 1'b1, 1'b1, 6'h22);
    chk("spare op done", 32'h1, {31'h0, opDone_r});
    chk("spare op result", '0, result_r);
    chk("spare op flags", 32'h3, {25'h0, fl});
    $display("spare op done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("rerun flags", '0, {25'h0, fl});
    chk("rerun dest", '0, {26'h0, resultDest_r});
    chk("rerun done", '0, {31'h0, opDone_r});
    chk("rerun write", '0, {31'h0, resultWe_r});
    $display("mid-run reset done");
    complete_run;
  end
endmodule // test_scaled_and_saturating_subtract_alu
